// ### verilog/cbc_pkg.sv
// cbc_pkg: shared constants and types for the coefficient buffer controller
// assumes one 200 MHz clock shared by host end and device end
package cbc_pkg;
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned COEF_W        = 16;
	localparam int unsigned COEF_N        = 63;
	localparam int unsigned IDX_W         = 6;
	localparam int unsigned UNITY_STRIDE  = 5;

	localparam logic [7:0] REG_PAGE       = 8'h00;
	localparam logic [7:0] REG_CTRL       = 8'h01;
	localparam logic [7:0] REG_COEF_FIRST = 8'h02;
	localparam logic [7:0] REG_COEF_LAST  = 8'h7f;
	localparam logic [7:0] PAGE_RESET     = 8'h00;
	localparam logic [7:0] PAGE_COEF      = 8'h08;

	localparam int unsigned CTRL_SWAP_BIT   = 0;
	localparam int unsigned CTRL_OWNER_BIT  = 1;
	localparam int unsigned CTRL_ADAPT_BIT  = 2;
	localparam int unsigned CTRL_TOGGLE_BIT = 3;
	localparam logic [7:0]  CTRL_RSVD_MASK  = 8'hf0;

	localparam logic [15:0] COEF_UNITY    = 16'h7fff;
	localparam logic [15:0] COEF_ZERO     = 16'h0000;

	localparam int unsigned INIT_TIME_US  = 100;
	localparam int unsigned CLK_MHZ       = 200;
	localparam int unsigned INIT_CYCLES   = INIT_TIME_US * CLK_MHZ;

	localparam logic [1:0] CMD_WRITE      = 2'h0;
	localparam logic [1:0] CMD_READ       = 2'h1;
	localparam logic [1:0] CMD_COEF       = 2'h2;

	typedef logic signed [COEF_W-1:0] cbc_coef_t;

	typedef enum logic [4:0] {
		H_IDLE   = 5'b0_0001,
		H_SEL    = 5'b0_0010,
		H_PAGE   = 5'b0_0100,
		H_ACC    = 5'b0_1000,
		H_RDWAIT = 5'b1_0000
	} cbc_host_state_t;
endpackage : cbc_pkg

// ### verilog/cbc_link_if.sv
// cbc_link_if: register link between host end and device end
// assumes both ends clocked by the same i_ref_clk
`timescale 1ns/100ps
interface cbc_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       lsb_wr;
	logic [7:0] rdata;
	logic       ready;

	modport dev  (input addr, input wdata, input wr, input rd, input lsb_wr, output rdata, output ready);
	modport host (output addr, output wdata, output wr, output rd, output lsb_wr, input rdata, input ready);
endinterface : cbc_link_if

// ### verilog/cbc_coef_bank.sv
// cbc_coef_bank: one buffer of 63 signed coefficients, byte-wide writes
// assumes the caller registers whatever it reads out
`timescale 1ns/100ps
module cbc_coef_bank
	import cbc_pkg::*;
#(
	parameter int unsigned N = cbc_pkg::COEF_N
)(
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_wr_en,
	input  wire logic [cbc_pkg::IDX_W-1:0] i_wr_idx,
	input  wire logic                     i_wr_hi,
	input  wire logic [7:0]               i_wr_byte,
	input  wire logic [cbc_pkg::IDX_W-1:0] i_rd_idx_a,
	input  wire logic [cbc_pkg::IDX_W-1:0] i_rd_idx_b,
	output cbc_pkg::cbc_coef_t            o_rd_a,
	output cbc_pkg::cbc_coef_t            o_rd_b
);
	cbc_coef_t mem_ff [N];

	genvar k;
	generate
		for (k = 0; k < N; k++)
		begin : g_entry
			// every fifth coefficient resets to unity
			always_ff @(posedge i_ref_clk or posedge i_rst)
			begin
				if (i_rst)
					mem_ff[k] <= ((k % UNITY_STRIDE) == 0) ? COEF_UNITY : COEF_ZERO;
				else if (i_wr_en && (i_wr_idx == IDX_W'(k)))
				begin
					if (i_wr_hi)
						mem_ff[k][15:8] <= i_wr_byte;
					else
						mem_ff[k][7:0] <= i_wr_byte;
				end
			end
		end
	endgenerate

	// index 63 is past the end and reads zero
	assign o_rd_a = (32'(i_rd_idx_a) < N) ? mem_ff[i_rd_idx_a] : '0;
	assign o_rd_b = (32'(i_rd_idx_b) < N) ? mem_ff[i_rd_idx_b] : '0;
endmodule : cbc_coef_bank

// ### verilog/cbc_dev.sv
// cbc_dev: paged register bank with a double-buffered coefficient memory
// assumes frame sync and toggle flag come from processor logic on i_ref_clk
`timescale 1ns/100ps
module cbc_dev
	import cbc_pkg::*;
#(
	parameter int unsigned INIT_CYC = cbc_pkg::INIT_CYCLES
)(
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	cbc_link_if.dev                       link,
	input  wire logic                     i_frame_sync,
	input  wire logic                     i_proc_toggle,
	input  wire logic [cbc_pkg::IDX_W-1:0] i_proc_idx,
	output cbc_pkg::cbc_coef_t            o_proc_coef,
	output logic                          o_adaptive_en,
	output logic                          o_proc_buf_b,
	output logic                          o_host_buf_b,
	output logic                          o_defaults_valid
);
	import cbc_pkg::*;

	logic [7:0]       page_ff;
	logic             adapt_ff;
	logic             owner_ff;
	logic             swap_req_ff;
	logic             nxt_swap_req;
	logic             toggle_ff;
	logic [31:0]      init_cnt_ff;
	logic             init_done_ff;
	logic [7:0]       rdata_ff;
	logic [7:0]       nxt_rdata;
	cbc_coef_t        proc_coef_ff;

	logic             on_coef_page;
	logic             wr_page;
	logic             wr_ctrl;
	logic             coef_hit;
	logic [7:0]       coef_off;
	logic [IDX_W-1:0] host_idx;
	logic             host_hi;
	logic             host_buf_b;
	logic             proc_buf_b;
	logic             swap_now;
	logic             bank_wr;
	cbc_coef_t        a_host;
	cbc_coef_t        a_proc;
	cbc_coef_t        b_host;
	cbc_coef_t        b_proc;
	cbc_coef_t        host_coef;

	////////////////////////////////////////////////////////////////////////
	// address decode

	assign on_coef_page = (page_ff == PAGE_COEF);
	// page select reachable on every page
	assign wr_page      = link.wr && (link.addr == REG_PAGE);
	assign wr_ctrl      = link.wr && on_coef_page && (link.addr == REG_CTRL);
	assign coef_hit     = on_coef_page && (link.addr >= REG_COEF_FIRST) && (link.addr <= REG_COEF_LAST);
	assign coef_off     = link.addr - REG_COEF_FIRST;
	assign host_idx     = coef_off[IDX_W:1];
	assign host_hi      = ~coef_off[0];
	assign bank_wr      = link.wr && coef_hit;

	////////////////////////////////////////////////////////////////////////
	// buffer routing

	// owner 0 in adaptive mode: processor on A, host on B; host on A when not adaptive
	assign host_buf_b = adapt_ff & ~owner_ff;
	// toggle flag picks the buffer outside adaptive mode
	assign proc_buf_b = adapt_ff ? owner_ff : toggle_ff;
	assign swap_now   = i_frame_sync && swap_req_ff && adapt_ff;

	cbc_coef_bank #(
		.N          (COEF_N)
	) u_bank_a (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_wr_en    (bank_wr && !host_buf_b),
		.i_wr_idx   (host_idx),
		.i_wr_hi    (host_hi),
		.i_wr_byte  (link.wdata),
		.i_rd_idx_a (host_idx),
		.i_rd_idx_b (i_proc_idx),
		.o_rd_a     (a_host),
		.o_rd_b     (a_proc)
	);

	cbc_coef_bank #(
		.N          (COEF_N)
	) u_bank_b (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_wr_en    (bank_wr && host_buf_b),
		.i_wr_idx   (host_idx),
		.i_wr_hi    (host_hi),
		.i_wr_byte  (link.wdata),
		.i_rd_idx_a (host_idx),
		.i_rd_idx_b (i_proc_idx),
		.o_rd_a     (b_host),
		.o_rd_b     (b_proc)
	);

	assign host_coef = host_buf_b ? b_host : a_host;

	////////////////////////////////////////////////////////////////////////
	// page select

	// eight-bit page select, resets to page 0
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			page_ff <= PAGE_RESET;
		else if (wr_page)
			page_ff <= link.wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// buffer control register

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			adapt_ff <= 1'b0;
		else if (wr_ctrl)
			adapt_ff <= link.wdata[CTRL_ADAPT_BIT];
	end

	// processor flag mirrored, host cannot write it
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			toggle_ff <= 1'b0;
		else
			toggle_ff <= i_proc_toggle;
	end

	// swap flips ownership at the frame edge
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			owner_ff <= 1'b0;
		else if (swap_now)
			owner_ff <= ~owner_ff;
	end

	// request sets only with adaptive on; set beats clear
	always_comb
	begin
		nxt_swap_req = swap_req_ff;
		if (swap_now || !adapt_ff)
			nxt_swap_req = 1'b0;
		if (wr_ctrl && link.wdata[CTRL_SWAP_BIT] && link.wdata[CTRL_ADAPT_BIT])
			nxt_swap_req = 1'b1;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			swap_req_ff <= 1'b0;
		else
			swap_req_ff <= nxt_swap_req;
	end

	////////////////////////////////////////////////////////////////////////
	// default settle timer

	// count out the settle interval after reset
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			init_cnt_ff  <= '0;
			init_done_ff <= 1'b0;
		end
		else if (!init_done_ff)
		begin
			init_cnt_ff  <= init_cnt_ff + 32'd1;
			init_done_ff <= (init_cnt_ff == 32'(INIT_CYC - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data and processor port

	always_comb
	begin
		nxt_rdata = '0;
		if (link.addr == REG_PAGE)
			nxt_rdata = page_ff;
		else if (on_coef_page && (link.addr == REG_CTRL))
			nxt_rdata = {4'h0, toggle_ff, adapt_ff, owner_ff, swap_req_ff};
		else if (coef_hit)
			nxt_rdata = host_hi ? host_coef[15:8] : host_coef[7:0];
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			rdata_ff <= '0;
		else
			rdata_ff <= link.rd ? nxt_rdata : 8'h00;
	end

	// signed coefficient to the processor, one cycle after index
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			proc_coef_ff <= '0;
		else
			proc_coef_ff <= proc_buf_b ? b_proc : a_proc;
	end

	assign link.rdata       = rdata_ff;
	assign link.ready       = init_done_ff;
	assign o_proc_coef      = proc_coef_ff;
	assign o_adaptive_en    = adapt_ff;
	assign o_proc_buf_b     = proc_buf_b;
	assign o_host_buf_b     = host_buf_b;
	assign o_defaults_valid = init_done_ff;
endmodule : cbc_dev

// ### verilog/cbc_host.sv
// cbc_host: control-side master that pages, writes and reads the device
// assumes user commands on i_ref_clk, one outstanding at a time
`timescale 1ns/100ps
module cbc_host
	import cbc_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	cbc_link_if.host         link,
	input  wire logic        i_cmd_valid,
	input  wire logic [1:0]  i_cmd_kind,
	input  wire logic [7:0]  i_cmd_page,
	input  wire logic [7:0]  i_cmd_reg,
	input  wire logic [15:0] i_cmd_data,
	output logic             o_cmd_ready,
	output logic             o_cmd_refused,
	output logic             o_rsp_valid,
	output logic [7:0]       o_rsp_data
);
	import cbc_pkg::*;

	cbc_host_state_t state_ff;
	logic [1:0]      kind_ff;
	logic [7:0]      page_ff;
	logic [7:0]      reg_ff;
	logic [15:0]     data_ff;
	logic [7:0]      cur_page_ff;
	logic [7:0]      addr_ff;
	logic [7:0]      wdata_ff;
	logic            wr_ff;
	logic            rd_ff;
	logic            lsb_ff;
	logic            refused_ff;
	logic            rsp_valid_ff;
	logic [7:0]      rsp_data_ff;
	logic            bad;
	logic [7:0]      tgt_page;
	logic [7:0]      acc_addr;
	logic [7:0]      acc_data;

	// writes to reserved coefficient-page registers and bad indices refused
	assign bad = (i_cmd_kind == CMD_COEF) ? (32'(i_cmd_reg) >= COEF_N) :
		(i_cmd_kind == CMD_WRITE) && (i_cmd_page == PAGE_COEF) && (i_cmd_reg > REG_COEF_LAST);
	assign tgt_page = (i_cmd_kind == CMD_COEF) ? PAGE_COEF : i_cmd_page;

	always_comb
	begin
		acc_addr = reg_ff;
		acc_data = data_ff[7:0];
		if (kind_ff == CMD_COEF)
		begin
			acc_addr = REG_COEF_FIRST + {reg_ff[6:0], 1'b0};
			acc_data = data_ff[15:8];
		end
		// reserved control bits always sent as zero
		else if ((page_ff == PAGE_COEF) && (reg_ff == REG_CTRL))
			acc_data = data_ff[7:0] & ~CTRL_RSVD_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff     <= H_IDLE;
			kind_ff      <= CMD_WRITE;
			page_ff      <= PAGE_RESET;
			reg_ff       <= '0;
			data_ff      <= '0;
			cur_page_ff  <= PAGE_RESET;
			addr_ff      <= '0;
			wdata_ff     <= '0;
			wr_ff        <= 1'b0;
			rd_ff        <= 1'b0;
			lsb_ff       <= 1'b0;
			refused_ff   <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= '0;
		end
		else
		begin
			wr_ff        <= 1'b0;
			rd_ff        <= 1'b0;
			lsb_ff       <= 1'b0;
			refused_ff   <= 1'b0;
			rsp_valid_ff <= 1'b0;
			case (state_ff)
				H_IDLE:
				begin
					// nothing issued until defaults have settled
					if (i_cmd_valid && link.ready)
					begin
						if (bad)
							refused_ff <= 1'b1;
						else
						begin
							kind_ff  <= i_cmd_kind;
							page_ff  <= tgt_page;
							reg_ff   <= i_cmd_reg;
							data_ff  <= i_cmd_data;
							state_ff <= H_SEL;
						end
					end
				end
				H_SEL:
				begin
					if ((page_ff != cur_page_ff) && !((kind_ff == CMD_WRITE) && (reg_ff == REG_PAGE)))
					begin
						addr_ff     <= REG_PAGE;
						wdata_ff    <= page_ff;
						wr_ff       <= 1'b1;
						cur_page_ff <= page_ff;
						state_ff    <= H_PAGE;
					end
					else
					begin
						addr_ff  <= acc_addr;
						wdata_ff <= acc_data;
						wr_ff    <= (kind_ff != CMD_READ);
						rd_ff    <= (kind_ff == CMD_READ);
						state_ff <= H_ACC;
						if ((kind_ff == CMD_WRITE) && (reg_ff == REG_PAGE))
							cur_page_ff <= data_ff[7:0];
					end
				end
				H_PAGE:
				begin
					addr_ff  <= acc_addr;
					wdata_ff <= acc_data;
					wr_ff    <= (kind_ff != CMD_READ);
					rd_ff    <= (kind_ff == CMD_READ);
					state_ff <= H_ACC;
				end
				H_ACC:
				begin
					if (kind_ff == CMD_COEF)
					begin
						// lower byte right behind the upper byte
						addr_ff  <= addr_ff + 8'h01;
						wdata_ff <= data_ff[7:0];
						wr_ff    <= 1'b1;
						lsb_ff   <= 1'b1;
						kind_ff  <= CMD_WRITE;
						state_ff <= H_IDLE;
					end
					else if (kind_ff == CMD_READ)
						state_ff <= H_RDWAIT;
					else
						state_ff <= H_IDLE;
				end
				H_RDWAIT:
				begin
					rsp_data_ff  <= link.rdata;
					rsp_valid_ff <= 1'b1;
					state_ff     <= H_IDLE;
				end
				default:
					state_ff <= H_IDLE;
			endcase
		end
	end

	assign link.addr     = addr_ff;
	assign link.wdata    = wdata_ff;
	assign link.wr       = wr_ff;
	assign link.rd       = rd_ff;
	assign link.lsb_wr   = lsb_ff;
	assign o_cmd_ready   = (state_ff == H_IDLE) && link.ready;
	assign o_cmd_refused = refused_ff;
	assign o_rsp_valid   = rsp_valid_ff;
	assign o_rsp_data    = rsp_data_ff;
endmodule : cbc_host

// ### verification/cbc_link_sva.sv
// cbc_link_sva: protocol checks on the host-to-device register link
// assumes one clock, async high reset, instantiated beside the link
`timescale 1ns/100ps
module cbc_link_sva
	import cbc_pkg::*;
#(
	parameter int unsigned INIT_CYC = cbc_pkg::INIT_CYCLES
)(
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic       lsb_wr,
	input wire logic [7:0] rdata,
	input wire logic       ready
);
	logic [7:0]  page_ff;
	int unsigned wait_ff;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////
	// page as the device sees it, so checks need no hierarchy
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			page_ff <= PAGE_RESET;
		else if (wr && addr == REG_PAGE)
			page_ff <= wdata;
	end
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			wait_ff <= 0;
		else if (!ready)
			wait_ff <= wait_ff + 1;
	end
	////////////////////////////////////////////////////////////////
	a_strobe_apart: assert property (!(wr && rd))
		else $error("strobes overlap");
	a_read_single: assert property (rd |=> !rd)
		else $error("read strobe too long");
	a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside answer cycle");
	a_page_echo: assert property (rd && addr == REG_PAGE |=> rdata == page_ff)
		else $error("page select read back wrong");
	a_no_early: assert property (!ready |-> !wr && !rd)
		else $error("access before defaults settle");
	a_ready_held: assert property (ready |=> ready)
		else $error("ready dropped");
	// slack of one edge either way on when counting starts
	a_ready_time: assert property ($rose(ready) |-> wait_ff + 1 >= INIT_CYC && wait_ff <= INIT_CYC + 1)
		else $error("ready at wrong time");
	a_low_follows: assert property (lsb_wr |-> wr && addr[0] && $past(wr) && addr == $past(addr) + 8'h01)
		else $error("low byte not right after high byte");
	a_pair_whole: assert property (wr && !lsb_wr && page_ff == PAGE_COEF && addr >= REG_COEF_FIRST
		|=> wr && lsb_wr)
		else $error("high byte without low byte");
	a_ctrl_zeros: assert property (wr && addr == REG_CTRL && page_ff == PAGE_COEF
		|-> (wdata & CTRL_RSVD_MASK) == 8'h00)
		else $error("reserved control bits written");
	a_no_reserved: assert property (wr && page_ff == PAGE_COEF |-> addr <= REG_COEF_LAST)
		else $error("reserved register written");
	c_pair: cover property (lsb_wr);
	c_page: cover property (wr && addr == REG_PAGE);
	c_ctrl_rd: cover property (rd && addr == REG_CTRL && page_ff == PAGE_COEF);
endmodule : cbc_link_sva

// ### verification/tb.sv
// tb: host end and device end on one link, plus a bench-driven device
// assumes package, link, both ends and checker compiled first
`timescale 1ns/100ps
module tb;
	import cbc_pkg::*;
	localparam int unsigned INIT_N = 8;
	logic        i_ref_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        fs = 1'b0;
	logic        tog = 1'b0;
	logic [5:0]  pidx = '0;
	logic        cv = 1'b0;
	logic [1:0]  ck = '0;
	logic [7:0]  cp = '0;
	logic [7:0]  cr = '0;
	logic [15:0] cd = '0;
	cbc_coef_t   pcoef;
	logic        adapt, pbuf, hbuf, dval, crdy, cref, rv;
	logic [7:0]  rdat;
	int          n_errors = 0;
	int          samples_checked = 0;
	cbc_link_if  link_a();
	cbc_link_if  link_b();
	always #2.5 i_ref_clk = ~i_ref_clk;
	cbc_dev #(.INIT_CYC(INIT_N)) cbc_dev_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link_a.dev),
		.i_frame_sync(fs), .i_proc_toggle(tog), .i_proc_idx(pidx), .o_proc_coef(pcoef), .o_adaptive_en(adapt),
		.o_proc_buf_b(pbuf), .o_host_buf_b(hbuf), .o_defaults_valid(dval));
	cbc_host cbc_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link_a.host), .i_cmd_valid(cv),
		.i_cmd_kind(ck), .i_cmd_page(cp), .i_cmd_reg(cr), .i_cmd_data(cd), .o_cmd_ready(crdy),
		.o_cmd_refused(cref), .o_rsp_valid(rv), .o_rsp_data(rdat));
	// second device: the bench plays a host that breaks the rules
	cbc_dev #(.INIT_CYC(INIT_N)) cbc_dev_inst2 (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link_b.dev),
		.i_frame_sync(fs), .i_proc_toggle(tog), .i_proc_idx(pidx), .o_proc_coef(), .o_adaptive_en(),
		.o_proc_buf_b(), .o_host_buf_b(), .o_defaults_valid());
	cbc_link_sva #(.INIT_CYC(INIT_N)) cbc_link_sva_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.addr(link_a.addr), .wdata(link_a.wdata), .wr(link_a.wr), .rd(link_a.rd), .lsb_wr(link_a.lsb_wr),
		.rdata(link_a.rdata), .ready(link_a.ready));
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic give_up();
		n_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		wrap_up();
	endtask : give_up
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : tick
	////////////////////////////////////////////////////////////////
	task automatic host_cmd(input logic [1:0] k, input logic [7:0] pg, input logic [7:0] rg, input logic [15:0] d);
		int n = 0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (crdy !== 1'b1 && n < 100);
		if (crdy !== 1'b1)
			give_up();
		cv <= 1'b1;
		ck <= k;
		cp <= pg;
		cr <= rg;
		cd <= d;
		@(posedge i_ref_clk);
		cv <= 1'b0;
	endtask : host_cmd
	task automatic host_rd(input logic [7:0] pg, input logic [7:0] rg, output logic [7:0] d);
		int n = 0;
		host_cmd(CMD_READ, pg, rg, 16'h0000);
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (rv !== 1'b1 && n < 10);
		if (rv !== 1'b1)
			give_up();
		d = rdat;
	endtask : host_rd
	task automatic host_chk(input logic [7:0] pg, input logic [7:0] rg, input logic [7:0] exp);
		logic [7:0] v;
		host_rd(pg, rg, v);
		chk({8'h00, v}, {8'h00, exp});
	endtask : host_chk
	task automatic refused_chk();
		logic seen = 1'b0;
		repeat (3)
		begin
			@(posedge i_ref_clk);
			seen = seen | (cref === 1'b1);
		end
		chk_bit(seen, 1'b1);
	endtask : refused_chk
	task automatic b_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		link_b.wr <= 1'b1;
		link_b.addr <= a;
		link_b.wdata <= d;
		@(posedge i_ref_clk);
		link_b.wr <= 1'b0;
		link_b.wdata <= ~d;
	endtask : b_wr
	task automatic b_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		link_b.rd <= 1'b1;
		link_b.addr <= a;
		@(posedge i_ref_clk);
		link_b.rd <= 1'b0;
		@(posedge i_ref_clk);
		chk({8'h00, link_b.rdata}, {8'h00, exp});
	endtask : b_chk
	task automatic coef_chk(input logic [5:0] k, input logic [15:0] exp);
		@(posedge i_ref_clk);
		pidx <= k;
		tick(2);
		chk(pcoef, exp);
	endtask : coef_chk
	////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		for (int k = 0; k < 63; k++)
			coef_chk(k[5:0], (k % 5 == 0) ? COEF_UNITY : COEF_ZERO);
		b_chk(REG_PAGE, PAGE_RESET);
		b_wr(REG_PAGE, PAGE_COEF);
		b_chk(REG_PAGE, PAGE_COEF);
		b_chk(8'h02, 8'h7f);
		b_chk(8'h03, 8'hff);
		b_chk(8'h0c, 8'h7f);
		b_chk(REG_CTRL, 8'h00);
		$display("defaults done");
	endtask : t_defaults
	task automatic t_faults();
		b_wr(8'h80, 8'haa);
		b_chk(8'h80, 8'h00);
		b_wr(REG_CTRL, 8'hf4);
		b_chk(REG_CTRL, 8'h04);
		b_wr(REG_CTRL, 8'h00);
		b_wr(REG_CTRL, 8'h01);
		b_chk(REG_CTRL, 8'h00);
		b_wr(8'h04, 8'h55);
		b_chk(8'h04, 8'h55);
		b_chk(8'h05, 8'h00);
		$display("faults done");
	endtask : t_faults
	task automatic t_coef();
		host_cmd(CMD_COEF, 8'h00, 8'd62, 16'h8000);
		host_chk(PAGE_COEF, 8'd126, 8'h80);
		host_chk(PAGE_COEF, 8'd127, 8'h00);
		coef_chk(6'd62, 16'h8000);
		host_cmd(CMD_COEF, 8'h00, 8'd1, 16'h7fff);
		host_chk(PAGE_COEF, 8'd4, 8'h7f);
		coef_chk(6'd1, 16'h7fff);
		host_cmd(CMD_COEF, 8'h00, 8'd63, 16'h1111);
		refused_chk();
		host_cmd(CMD_WRITE, PAGE_COEF, 8'h80, 16'h00aa);
		refused_chk();
		$display("coefficients done");
	endtask : t_coef
	task automatic t_swap();
		host_cmd(CMD_WRITE, PAGE_COEF, REG_CTRL, 16'h00f5);
		host_chk(PAGE_COEF, REG_CTRL, 8'h05);
		chk_bit(adapt, 1'b1);
		chk_bit(hbuf, 1'b1);
		chk_bit(pbuf, 1'b0);
		host_cmd(CMD_COEF, 8'h00, 8'd0, 16'h1234);
		host_chk(PAGE_COEF, 8'h02, 8'h12);
		coef_chk(6'd0, COEF_UNITY);
		@(posedge i_ref_clk);
		fs <= 1'b1;
		@(posedge i_ref_clk);
		fs <= 1'b0;
		host_chk(PAGE_COEF, REG_CTRL, 8'h06);
		chk_bit(pbuf, 1'b1);
		chk_bit(hbuf, 1'b0);
		coef_chk(6'd0, 16'h1234);
		host_chk(PAGE_COEF, 8'h02, 8'h7f);
		$display("swap done");
	endtask : t_swap
	task automatic t_toggle();
		logic [7:0] v;
		host_cmd(CMD_WRITE, PAGE_COEF, REG_CTRL, 16'h0000);
		@(posedge i_ref_clk);
		tog <= 1'b1;
		host_rd(PAGE_COEF, REG_CTRL, v);
		chk_bit(v[CTRL_TOGGLE_BIT], 1'b1);
		chk_bit(v[CTRL_ADAPT_BIT], 1'b0);
		chk_bit(pbuf, 1'b1);
		chk_bit(hbuf, 1'b0);
		coef_chk(6'd0, 16'h1234);
		tog <= 1'b0;
		coef_chk(6'd0, COEF_UNITY);
		$display("toggle done");
	endtask : t_toggle
	// direct page-select write skips the paging step, then reads back on two pages
	task automatic t_page();
		host_cmd(CMD_WRITE, 8'h00, REG_PAGE, 16'h0003);
		host_chk(8'h03, REG_PAGE, 8'h03);
		host_chk(PAGE_COEF, REG_PAGE, PAGE_COEF);
		$display("page done");
	endtask : t_page
	// swap request written in the very cycle of the frame edge: swap and re-set
	task automatic t_race();
		b_wr(REG_CTRL, 8'h05);
		@(posedge i_ref_clk);
		link_b.wr    <= 1'b1;
		link_b.addr  <= REG_CTRL;
		link_b.wdata <= 8'h05;
		fs           <= 1'b1;
		@(posedge i_ref_clk);
		link_b.wr <= 1'b0;
		fs        <= 1'b0;
		b_chk(REG_CTRL, 8'h07);
		$display("race done");
	endtask : t_race
	////////////////////////////////////////////////////////////////
	initial
	begin
		link_b.addr = 8'h00;
		link_b.wdata = 8'h00;
		link_b.wr = 1'b0;
		link_b.rd = 1'b0;
		link_b.lsb_wr = 1'b0;
		tick(4);
		i_rst <= 1'b0;
		for (int n = 0; dval !== 1'b1; n++)
		begin
			if (n > 50)
				give_up();
			@(posedge i_ref_clk);
		end
		t_defaults();
		t_faults();
		t_coef();
		t_page();
		t_swap();
		t_toggle();
		t_race();
		wrap_up();
	end
endmodule : tb
